// *** design/rct_edge_if.sv ***
`timescale 1ns/10ps
interface rct_edge_if;
	import rct_pkg::*;
	logic [RCT_NUM_PINS-1:0] fall;
	modport src (output fall);
	modport dst (input fall);
endinterface

// *** design/rct_pin_sync.sv ***
`timescale 1ns/10ps
module rct_pin_sync
	import rct_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [RCT_NUM_PINS-1:0] pins_i,
	rct_edge_if.src ev
);
	genvar g;
	generate
		for (g = 0; g < RCT_NUM_PINS; g++) begin : g_pin
			logic s1_ff, s2_ff, s3_ff, lvl_ff, fall_ff;
			// three stages; a level counts once stages two and three agree
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					s1_ff <= 1'b1;
					s2_ff <= 1'b1;
					s3_ff <= 1'b1;
				end else begin
					s1_ff <= pins_i[g];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
				end
			end
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					lvl_ff <= 1'b1;
					fall_ff <= 1'b0;
				end else begin
					fall_ff <= (s2_ff == s3_ff) && !s2_ff && lvl_ff;
					if (s2_ff == s3_ff)
						lvl_ff <= s2_ff;
				end
			end
			assign ev.fall[g] = fall_ff;
			property p_one_event;
				@(posedge sys_clk_i) disable iff (!rst_n_i)
				fall_ff |=> !fall_ff;
			endproperty
			a_one_event: assert property (p_one_event) else $error("double edge event");
		end
	endgenerate
endmodule // rct_pin_sync

// *** design/rct_pkg.sv ***
package rct_pkg;
	// ------------------------------------------------------------
	// register offsets in the special function register space
	// ------------------------------------------------------------
	localparam logic [7:0] RCT_OFS_CTRL = 8'hC8;
	localparam logic [7:0] RCT_OFS_RCAP_LO = 8'hCA;
	localparam logic [7:0] RCT_OFS_RCAP_HI = 8'hCB;
	localparam logic [7:0] RCT_OFS_CNT_LO = 8'hCC;
	localparam logic [7:0] RCT_OFS_CNT_HI = 8'hCD;
	// ------------------------------------------------------------
	// control register fields and reset values
	// ------------------------------------------------------------
	localparam int RCT_BIT_OVF = 7;
	localparam int RCT_BIT_EXF = 6;
	localparam int RCT_BIT_RCLK = 5;
	localparam int RCT_BIT_TRANSMIT_CLOCK_SELECT = 4;
	localparam int RCT_BIT_EXEN = 3;
	localparam int RCT_BIT_RUN = 2;
	localparam int RCT_BIT_CT = 1;
	localparam int RCT_BIT_CPRL = 0;
	localparam logic [7:0] RCT_CTRL_RST = 8'h00;
	localparam logic [15:0] RCT_DATA_RST = 16'h0000;
	localparam logic [15:0] RCT_CNT_MAX = 16'hFFFF;
	localparam logic [7:0] RCT_RD_UNMAPPED = 8'h00;
	// ------------------------------------------------------------
	// pin indices and timing
	// ------------------------------------------------------------
	localparam int RCT_NUM_PINS = 2;
	localparam int RCT_PIN_COUNT = 0;
	localparam int RCT_PIN_TRIG = 1;
	localparam int RCT_TIMER_DIV = 2;
endpackage

// *** design/rct_timer.sv ***
// How it works
// - overflow sets overflow flag unless a baud select bit is set; software clears.
// - trigger edge causing capture or reload sets external trigger flag; software clears.
// - receive baud tick from this overflow when set, else other timer's.
// - transmit baud tick from this overflow when set, else other timer's.
// - trigger edge acts only with trigger enable and both baud selects clear.
// - counter advances only while run control is set.
// - timer mode increments once every two system clocks.
// - counter mode increments once per falling count pin edge.
// - reload mode loads counter from reload value on overflow or trigger.
// - capture mode copies counter into reload register on trigger edge.
// - any baud select forces reload on overflow, capture select ignored.
// - counter and reload value are byte-accessible 16-bit registers, reset zero.
`timescale 1ns/10ps
module rct_timer
	import rct_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic count_pin_i,
	input wire logic trigger_pin_i,
	input wire logic other_timer_ovf_i,
	output logic rx_baud_tick_o,
	output logic tx_baud_tick_o,
	output logic timer_irq_o
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rs1_ff, rs2_ff, rst_n;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rs1_ff <= 1'b0;
			rs2_ff <= 1'b0;
		end else begin
			rs1_ff <= 1'b1;
			rs2_ff <= rs1_ff;
		end
	end
	assign rst_n = rs2_ff;

	// ------------------------------------------------------------
	// pin edges
	// ------------------------------------------------------------
	rct_edge_if edges ();
	rct_pin_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.pins_i({trigger_pin_i, count_pin_i}),
		.ev(edges.src)
	);
	logic cnt_ev, trig_ev;
	assign cnt_ev = edges.fall[RCT_PIN_COUNT];
	assign trig_ev = edges.fall[RCT_PIN_TRIG];

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic overflow_flag_ff, external_trigger_flag_ff;
	logic receive_clock_select_ff, transmit_clock_select_ff;
	logic trigger_input_enable_ff, run_control_ff;
	logic counter_timer_select_ff, capture_reload_select_ff;
	logic [15:0] cnt_ff, rcap_ff;
	logic div_ff;
	logic [7:0] rdata_ff;
	logic wr_ctrl, wr_cnt_lo, wr_cnt_hi, wr_rc_lo, wr_rc_hi;
	assign wr_ctrl = sfr_wr_i && (sfr_addr_i == RCT_OFS_CTRL);
	assign wr_rc_lo = sfr_wr_i && (sfr_addr_i == RCT_OFS_RCAP_LO);
	assign wr_rc_hi = sfr_wr_i && (sfr_addr_i == RCT_OFS_RCAP_HI);
	assign wr_cnt_lo = sfr_wr_i && (sfr_addr_i == RCT_OFS_CNT_LO);
	assign wr_cnt_hi = sfr_wr_i && (sfr_addr_i == RCT_OFS_CNT_HI);

	// ------------------------------------------------------------
	// counting events
	// ------------------------------------------------------------
	logic baud, tick, ovf, trig_act, do_reload, do_capture;
	assign baud = receive_clock_select_ff || transmit_clock_select_ff;
	assign tick = run_control_ff && (counter_timer_select_ff ? cnt_ev : div_ff);
	assign ovf = tick && (cnt_ff == RCT_CNT_MAX);
	assign trig_act = trig_ev && trigger_input_enable_ff && !baud;
	assign do_capture = trig_act && capture_reload_select_ff;
	assign do_reload = (ovf && (baud || !capture_reload_select_ff))
		|| (trig_act && !capture_reload_select_ff);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			div_ff <= 1'b0;
		else if (run_control_ff && !counter_timer_select_ff)
			div_ff <= !div_ff;
		else
			div_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// control register; hardware set wins over a clearing write
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag_ff <= RCT_CTRL_RST[RCT_BIT_OVF];
			external_trigger_flag_ff <= RCT_CTRL_RST[RCT_BIT_EXF];
		end else begin
			overflow_flag_ff <= (ovf && !baud)
				|| (wr_ctrl ? sfr_wdata_i[RCT_BIT_OVF] : overflow_flag_ff);
			external_trigger_flag_ff <= trig_act
				|| (wr_ctrl ? sfr_wdata_i[RCT_BIT_EXF] : external_trigger_flag_ff);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			receive_clock_select_ff <= RCT_CTRL_RST[RCT_BIT_RCLK];
			transmit_clock_select_ff <= RCT_CTRL_RST[RCT_BIT_TRANSMIT_CLOCK_SELECT];
			trigger_input_enable_ff <= RCT_CTRL_RST[RCT_BIT_EXEN];
			run_control_ff <= RCT_CTRL_RST[RCT_BIT_RUN];
			counter_timer_select_ff <= RCT_CTRL_RST[RCT_BIT_CT];
			capture_reload_select_ff <= RCT_CTRL_RST[RCT_BIT_CPRL];
		end else if (wr_ctrl) begin
			receive_clock_select_ff <= sfr_wdata_i[RCT_BIT_RCLK];
			transmit_clock_select_ff <= sfr_wdata_i[RCT_BIT_TRANSMIT_CLOCK_SELECT];
			trigger_input_enable_ff <= sfr_wdata_i[RCT_BIT_EXEN];
			run_control_ff <= sfr_wdata_i[RCT_BIT_RUN];
			counter_timer_select_ff <= sfr_wdata_i[RCT_BIT_CT];
			capture_reload_select_ff <= sfr_wdata_i[RCT_BIT_CPRL];
		end
	end

	// ------------------------------------------------------------
	// counter and reload/capture value
	// ------------------------------------------------------------
	// byte access; a software write beats the hardware update
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			cnt_ff <= RCT_DATA_RST;
		else if (wr_cnt_lo)
			cnt_ff[7:0] <= sfr_wdata_i;
		else if (wr_cnt_hi)
			cnt_ff[15:8] <= sfr_wdata_i;
		else if (do_reload)
			cnt_ff <= rcap_ff;
		else if (tick)
			cnt_ff <= cnt_ff + 16'h0001;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			rcap_ff <= RCT_DATA_RST;
		else if (wr_rc_lo)
			rcap_ff[7:0] <= sfr_wdata_i;
		else if (wr_rc_hi)
			rcap_ff[15:8] <= sfr_wdata_i;
		else if (do_capture)
			rcap_ff <= cnt_ff;
	end

	// ------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			rdata_ff <= RCT_RD_UNMAPPED;
		else if (sfr_rd_i) begin
			unique case (sfr_addr_i)
				RCT_OFS_CTRL: rdata_ff <= {overflow_flag_ff, external_trigger_flag_ff,
					receive_clock_select_ff, transmit_clock_select_ff,
					trigger_input_enable_ff, run_control_ff,
					counter_timer_select_ff, capture_reload_select_ff};
				RCT_OFS_RCAP_LO: rdata_ff <= rcap_ff[7:0];
				RCT_OFS_RCAP_HI: rdata_ff <= rcap_ff[15:8];
				RCT_OFS_CNT_LO: rdata_ff <= cnt_ff[7:0];
				RCT_OFS_CNT_HI: rdata_ff <= cnt_ff[15:8];
				default: rdata_ff <= RCT_RD_UNMAPPED;
			endcase
		end
	end
	assign sfr_rdata_o = rdata_ff;

	// ------------------------------------------------------------
	// baud and interrupt outputs
	// ------------------------------------------------------------
	// receive and transmit routing
	assign rx_baud_tick_o = receive_clock_select_ff ? ovf : other_timer_ovf_i;
	assign tx_baud_tick_o = transmit_clock_select_ff ? ovf : other_timer_ovf_i;
	assign timer_irq_o = overflow_flag_ff || external_trigger_flag_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	logic quiet;
	assign quiet = !sfr_wr_i;

	sequence s_timer_idle;
		run_control_ff && !counter_timer_select_ff && !tick && quiet;
	endsequence

	property p_ovf_flag;
		ovf && !baud |=> overflow_flag_ff;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missed");

	property p_ovf_baud;
		baud && !overflow_flag_ff && quiet |=> !overflow_flag_ff;
	endproperty
	a_ovf_baud: assert property (p_ovf_baud) else $error("flag set in baud use");

	property p_exf;
		trig_ev && trigger_input_enable_ff && !baud |=> external_trigger_flag_ff;
	endproperty
	a_exf: assert property (p_exf) else $error("trigger flag missed");

	property p_rx;
		receive_clock_select_ff && tick && cnt_ff == RCT_CNT_MAX |-> rx_baud_tick_o;
	endproperty
	a_rx: assert property (p_rx) else $error("receive baud tick missing");

	property p_tx;
		!transmit_clock_select_ff |-> tx_baud_tick_o == other_timer_ovf_i;
	endproperty
	a_tx: assert property (p_tx) else $error("transmit baud not routed");

	property p_trig_off;
		!trigger_input_enable_ff && quiet |=> $stable(rcap_ff) && !$rose(external_trigger_flag_ff);
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger not ignored");

	// a trigger reload still loads a stopped counter; only advancing is barred
	property p_hold;
		!run_control_ff && !do_reload && quiet |=> $stable(cnt_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while stopped");

	property p_rate;
		s_timer_idle ##1 (run_control_ff && quiet) |-> tick ##1 !tick;
	endproperty
	a_rate: assert property (p_rate) else $error("timer rate not one per two");

	property p_count;
		counter_timer_select_ff && run_control_ff && cnt_ev && quiet && !trig_act
			&& cnt_ff != RCT_CNT_MAX |=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("count edge lost");

	property p_reload;
		ovf && (baud || !capture_reload_select_ff) && quiet |=> cnt_ff == $past(rcap_ff);
	endproperty
	a_reload: assert property (p_reload) else $error("reload missed");

	property p_capture;
		trig_act && capture_reload_select_ff && quiet |=> rcap_ff == $past(cnt_ff);
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");

	property p_irq;
		overflow_flag_ff || external_trigger_flag_ff |-> timer_irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request missing");
endmodule // rct_timer

// *** verif/rct_pin_model.sv ***
`timescale 1ns/10ps
module rct_pin_model (
	input wire logic sys_clk_i,
	output logic count_pin_o,
	output logic trigger_pin_o,
	output logic other_ovf_o
);
	// ------------------------------------------------------------
	// pins idle high, other timer quiet
	// ------------------------------------------------------------
	initial begin
		count_pin_o = 1'b1;
		trigger_pin_o = 1'b1;
		other_ovf_o = 1'b0;
	end
	// four cycles low and high, above the two cycle minimum
	task automatic fall(input bit trig);
		@(posedge sys_clk_i);
		#1;
		if (trig) begin
			trigger_pin_o = 1'b0;
		end else begin
			count_pin_o = 1'b0;
		end
		repeat (4) @(posedge sys_clk_i);
		#1;
		trigger_pin_o = 1'b1;
		count_pin_o = 1'b1;
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic pulse_other();
		@(posedge sys_clk_i);
		#1;
		other_ovf_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		other_ovf_o = 1'b0;
	endtask
endmodule // rct_pin_model

// *** verif/tb_reload_capture_timer.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_reload_capture_timer;
	import rct_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic cnt_pin, trig_pin, oth, rx_t, tx_t, irq;
	logic [7:0] a, b;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int rx_n = 0;
	int tx_n = 0;
	rct_timer rct_timer_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .sfr_addr_i(addr),
		.sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
		.count_pin_i(cnt_pin), .trigger_pin_i(trig_pin), .other_timer_ovf_i(oth),
		.rx_baud_tick_o(rx_t), .tx_baud_tick_o(tx_t), .timer_irq_o(irq));
	rct_pin_model rct_pin_model_inst (.sys_clk_i(sys_clk), .count_pin_o(cnt_pin),
		.trigger_pin_o(trig_pin), .other_ovf_o(oth));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		rx_n += rx_t;
		tx_n += tx_t;
		if (cyc == 4000) begin
			fails++;
			conclude();
		end
	end
	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		addr = ad;
		wdata = d;
		wr_s = 1'b1;
		@(posedge sys_clk);
		#1;
		wr_s = 1'b0;
	endtask
	task automatic wr16(input logic [7:0] ad, input logic [15:0] d);
		wr(ad, d[7:0]);
		wr(ad + 8'h01, d[15:8]);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		addr = ad;
		rd_s = 1'b1;
		@(posedge sys_clk);
		#1;
		rd_s = 1'b0;
		d = rdata;
	endtask
	task automatic prep(input logic [15:0] rc, input logic [15:0] cn);
		wr(RCT_OFS_CTRL, 8'h00);
		wr16(RCT_OFS_RCAP_LO, rc);
		wr16(RCT_OFS_CNT_LO, cn);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] ads [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
		foreach (ads[i]) begin
			rd(ads[i], a);
			`CHK("reset value", 8'h00, a)
		end
		$display("test reset done");
	endtask
	task automatic t_timer();
		prep(16'h0000, 16'h0000);
		wr(RCT_OFS_CTRL, 8'h04);
		rd(RCT_OFS_CNT_LO, a);
		repeat (18) @(posedge sys_clk);
		rd(RCT_OFS_CNT_LO, b);
		`CHK("ticks in 20 cycles", 8'h0A, b - a)
		wr(RCT_OFS_CTRL, 8'h00);
		rd(RCT_OFS_CNT_LO, a);
		repeat (10) @(posedge sys_clk);
		rd(RCT_OFS_CNT_LO, b);
		`CHK("held count", a, b)
		$display("test timer done");
	endtask
	task automatic t_ovf();
		prep(16'hFFF0, 16'hFFFE);
		wr(RCT_OFS_CTRL, 8'h04);
		repeat (10) @(posedge sys_clk);
		rd(RCT_OFS_CTRL, a);
		`CHK("flag set", 8'h84, a)
		`CHK("irq on overflow", 1'b1, irq)
		rd(RCT_OFS_CNT_HI, a);
		`CHK("reloaded high", 8'hFF, a)
		wr(RCT_OFS_CTRL, 8'h00);
		`CHK("irq cleared", 1'b0, irq)
		$display("test overflow done");
	endtask
	task automatic t_baud();
		logic [7:0] cf [2] = '{8'h25, 8'h14};
		foreach (cf[i]) begin
			prep(16'hFFF0, 16'hFFFE);
			rx_n = 0;
			tx_n = 0;
			wr(RCT_OFS_CTRL, cf[i]);
			rct_pin_model_inst.pulse_other();
			rct_pin_model_inst.pulse_other();
			repeat (12) @(posedge sys_clk);
			rd(RCT_OFS_CTRL, a);
			`CHK("no flag with baud", cf[i], a)
			wr(RCT_OFS_CTRL, 8'h00);
			`CHK("rx ticks", (i == 0) ? 1 : 2, rx_n)
			`CHK("tx ticks", (i == 0) ? 2 : 1, tx_n)
			rd(RCT_OFS_CNT_HI, a);
			`CHK("forced reload", 8'hFF, a)
		end
		$display("test baud done");
	endtask
	task automatic t_count();
		prep(16'h0000, 16'h0000);
		wr(RCT_OFS_CTRL, 8'h06);
		repeat (3) rct_pin_model_inst.fall(1'b0);
		rd(RCT_OFS_CNT_LO, a);
		`CHK("pin edges", 8'h03, a)
		$display("test count done");
	endtask
	task automatic t_trig();
		logic [7:0] cf [3] = '{8'h01, 8'h29, 8'h09};
		logic [7:0] lo [3] = '{8'h00, 8'h00, 8'h34};
		logic [7:0] ct [3] = '{8'h01, 8'h29, 8'h49};
		prep(16'h0000, 16'h1234);
		foreach (cf[i]) begin
			wr(RCT_OFS_CTRL, cf[i]);
			rct_pin_model_inst.fall(1'b1);
			rd(RCT_OFS_RCAP_LO, a);
			`CHK("capture low", lo[i], a)
			rd(RCT_OFS_CTRL, a);
			`CHK("trigger flag", ct[i], a)
		end
		rd(RCT_OFS_RCAP_HI, a);
		`CHK("capture high", 8'h12, a)
		wr(RCT_OFS_CTRL, 8'h08);
		wr16(RCT_OFS_RCAP_LO, 16'hABCD);
		rct_pin_model_inst.fall(1'b1);
		rd(RCT_OFS_CNT_HI, a);
		rd(RCT_OFS_CNT_LO, b);
		`CHK("trigger reload", 16'hABCD, {a, b})
		`CHK("irq on trigger", 1'b1, irq)
		$display("test trigger done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_timer();
		t_ovf();
		t_baud();
		t_count();
		t_trig();
		conclude();
	end
endmodule // tb_reload_capture_timer
